// >>> rtl/scspc_map.vh
// Contract
// - sync bit rate is osc/(8*4^n*(N+1))
// - two-bit select picks baud generator input
// - select 01 gives watch/2 or watch
// - clock stop bit 5 zero means standby
// - standby holds channel registers at initial
// - pin control bit 5 routes transmit pin
// - pin control bit 3 inverts transmit data
// - pin control bit 2 inverts receive data
// - pin control resets to D3
// - pin control bits 7,6 read one
`ifndef SCSPC_MAP_VH
`define SCSPC_MAP_VH
// ----------------------------------------
// register word addresses (byte addr / 4)
// ----------------------------------------
`define SCSPC_ADDR_W 4
`define SCSPC_A_CLKSTOP 4'h0
`define SCSPC_A_PINCTL 4'h1
`define SCSPC_A_DIVISOR 4'h2
`define SCSPC_A_MODE 4'h3
`define SCSPC_A_CTRL 4'h4
`define SCSPC_A_STATUS 4'h5
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCSPC_CLKSTOP_RST 8'hFF
`define SCSPC_PINCTL_RST 8'hD3
`define SCSPC_PINCTL_FIXED 8'hC0
`define SCSPC_PINCTL_WMASK 8'h2C
`define SCSPC_DIVISOR_RST 8'hFF
`define SCSPC_MODE_RST 8'h00
`define SCSPC_CTRL_RST 8'h00
`define SCSPC_BIT_STOP 5
`define SCSPC_BIT_TXFN 5
`define SCSPC_BIT_TXINV 3
`define SCSPC_BIT_RXINV 2
`define SCSPC_BIT_TE 5
`define SCSPC_BIT_RE 4
`define SCSPC_SEL_LO 0
`define SCSPC_SEL_HI 1
// ----------------------------------------
// prescaler select codes and divides
// ----------------------------------------
`define SCSPC_SEL_SYS 2'h0
`define SCSPC_SEL_WATCH 2'h1
`define SCSPC_SEL_DIV16 2'h2
`define SCSPC_SEL_DIV64 2'h3
`define SCSPC_DIV16_LAST 4'hF
`define SCSPC_DIV64_LAST 6'h3F
`define SCSPC_SYNC_HALF 2'h3
`endif

// >>> rtl/scspc_prescale.v
`timescale 1ns/1ps
// ----------------------------------------
// prescaler: one-cycle tick at chosen rate
// ----------------------------------------
`include "scspc_map.vh"
module scspc_prescale (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // control
    input wire run,
    input wire [1:0] sel,
    input wire sub_mode,
    input wire watch_tick,
    // output
    output reg tick_q
);
    reg [5:0] div_q;
    reg watch_half_q;
    reg tick_d;
    always @* begin
        case (sel)
            `SCSPC_SEL_SYS: tick_d = 1'b1;
            `SCSPC_SEL_WATCH: tick_d = watch_tick &
                (sub_mode | watch_half_q);
            `SCSPC_SEL_DIV16: tick_d = (div_q[3:0] == `SCSPC_DIV16_LAST);
            default: tick_d = (div_q == `SCSPC_DIV64_LAST);
        endcase
    end
    always @(posedge clk_sys) begin
        if (reset || !run) begin
            div_q <= 6'h00;
            watch_half_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_q + 6'h01;
            if (watch_tick)
                watch_half_q <= ~watch_half_q;
            tick_q <= tick_d;
        end
    end
endmodule

// >>> rtl/scspc_baudgen.v
`timescale 1ns/1ps
// ----------------------------------------
// divisor counter: N+1 ticks, then /8 phase
// ----------------------------------------
`include "scspc_map.vh"
module scspc_baudgen #(
    parameter W = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // control
    input wire run,
    input wire tick,
    input wire [W-1:0] divisor,
    // outputs
    output reg serial_clk_q,
    output reg bit_strobe_q
);
    reg [W-1:0] cnt_q;
    reg [1:0] phase_q;
    always @(posedge clk_sys) begin
        if (reset || !run) begin
            cnt_q <= {W{1'b0}};
            phase_q <= 2'h0;
            serial_clk_q <= 1'b1;
            bit_strobe_q <= 1'b0;
        end else begin
            bit_strobe_q <= 1'b0;
            if (tick) begin
                if (cnt_q >= divisor) begin
                    cnt_q <= {W{1'b0}};
                    phase_q <= phase_q + 2'h1;
                    // 4 divisor periods per half clock: 8 per bit
                    if (phase_q == `SCSPC_SYNC_HALF) begin
                        serial_clk_q <= ~serial_clk_q;
                        bit_strobe_q <= serial_clk_q;
                    end
                end else begin
                    cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// >>> rtl/scspc_top.v
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// ----------------------------------------
// serial channel clock, standby, pin control
// ----------------------------------------
`include "scspc_map.vh"
module scspc_top #(
    parameter DIV_W = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // avalon-mm slave
    input wire [`SCSPC_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // system state
    input wire watch_tick,
    input wire sub_mode,
    // shifter side
    input wire shifter_tx_data,
    output wire shifter_rx_data,
    output wire channel_run,
    output wire serial_clk,
    output wire bit_strobe,
    // shared pin and port
    input wire general_port_out,
    input wire general_port_oe,
    output wire general_port_in,
    input wire serial_rx_pin,
    input wire shared_pin_in,
    output wire shared_pin_out,
    output wire shared_pin_oe
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] clkstop_q;
    reg [7:0] pinctl_q;
    reg [DIV_W-1:0] bit_rate_divisor_q;
    reg [7:0] serial_mode_q;
    reg [7:0] serial_control_q;
    reg ack_q;
    wire req;
    wire wr_lane0;
    wire run;
    wire tick;
    wire tx_fn;
    wire tx_bit;
    wire [1:0] sel;

    // one wait cycle, then ack on the next edge
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_lane0 = avs_write & ack_q & avs_byteenable[0];

    function [7:0] merge_pinctl;
        input [7:0] wd;
        begin
            merge_pinctl = `SCSPC_PINCTL_FIXED |
                (wd & `SCSPC_PINCTL_WMASK) |
                (`SCSPC_PINCTL_RST & ~`SCSPC_PINCTL_WMASK &
                 ~`SCSPC_PINCTL_FIXED);
        end
    endfunction

    assign run = clkstop_q[`SCSPC_BIT_STOP];
    assign channel_run = run;

    always @(posedge clk_sys) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // clock stop and pin control live outside the channel
    always @(posedge clk_sys) begin
        if (reset) begin
            clkstop_q <= `SCSPC_CLKSTOP_RST;
            pinctl_q <= `SCSPC_PINCTL_RST;
        end else if (wr_lane0) begin
            if (avs_address == `SCSPC_A_CLKSTOP)
                clkstop_q[`SCSPC_BIT_STOP] <=
                    avs_writedata[`SCSPC_BIT_STOP];
            if (avs_address == `SCSPC_A_PINCTL)
                pinctl_q <= merge_pinctl(avs_writedata[7:0]);
        end
    end

    // channel registers: forced to initial while stopped
    always @(posedge clk_sys) begin
        if (reset || !run) begin
            bit_rate_divisor_q <= `SCSPC_DIVISOR_RST;
            serial_mode_q <= `SCSPC_MODE_RST;
            serial_control_q <= `SCSPC_CTRL_RST;
        end else if (wr_lane0) begin
            case (avs_address)
                `SCSPC_A_DIVISOR:
                    bit_rate_divisor_q <= avs_writedata[DIV_W-1:0];
                `SCSPC_A_MODE: serial_mode_q <= avs_writedata[7:0];
                `SCSPC_A_CTRL: serial_control_q <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            case (avs_address)
                `SCSPC_A_CLKSTOP: avs_readdata <= {24'h0, clkstop_q};
                `SCSPC_A_PINCTL: avs_readdata <= {24'h0, pinctl_q};
                `SCSPC_A_DIVISOR: avs_readdata <=
                    {{(32-DIV_W){1'b0}}, bit_rate_divisor_q};
                `SCSPC_A_MODE: avs_readdata <= {24'h0, serial_mode_q};
                `SCSPC_A_CTRL: avs_readdata <= {24'h0, serial_control_q};
                `SCSPC_A_STATUS: avs_readdata <=
                    {29'h0, serial_clk, tx_fn, run};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // bit rate clock
    // ----------------------------------------
    assign sel = {serial_mode_q[`SCSPC_SEL_HI],
                  serial_mode_q[`SCSPC_SEL_LO]};

    scspc_prescale u_pre (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(run),
        .sel(sel),
        .sub_mode(sub_mode),
        .watch_tick(watch_tick),
        .tick_q(tick)
    );

    scspc_baudgen #(.W(DIV_W)) u_bg (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(run),
        .tick(tick),
        .divisor(bit_rate_divisor_q),
        .serial_clk_q(serial_clk),
        .bit_strobe_q(bit_strobe)
    );

    // ----------------------------------------
    // pins
    // ----------------------------------------
    // transmit only drives once routed; enable order is software's job
    assign tx_fn = pinctl_q[`SCSPC_BIT_TXFN];
    assign tx_bit = serial_control_q[`SCSPC_BIT_TE] & run ?
        shifter_tx_data : 1'b1;
    assign shared_pin_out = tx_fn ?
        (tx_bit ^ pinctl_q[`SCSPC_BIT_TXINV]) : general_port_out;
    assign shared_pin_oe = tx_fn ? 1'b1 : general_port_oe;
    assign general_port_in = shared_pin_in;
    assign shifter_rx_data = run ?
        (serial_rx_pin ^ pinctl_q[`SCSPC_BIT_RXINV]) : 1'b1;
endmodule

// >>> tb/scspc_remote.sv
`timescale 1ns/1ps
// ----
// remote serial device
// ----
module scspc_remote (
    // remote transmit line
    input wire send,
    input wire bit_in,
    output wire rx_line,
    // shared pin wire
    input wire pin_out,
    input wire pin_oe,
    output wire pin_level
);
    // idle line rests at mark level, never a stale bit
    assign rx_line = send ? bit_in : 1'b1;
    // pull-up holds the wire when nobody drives it
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

// >>> tb/scspc_chk_assertions.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module scspc_chk (
    // clock, reset, bus
    input wire clk_sys,
    input wire reset,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // channel and pins
    input wire shifter_rx_data,
    input wire channel_run,
    input wire serial_clk,
    input wire bit_strobe,
    input wire general_port_out,
    input wire general_port_oe,
    input wire serial_rx_pin,
    input wire shared_pin_out,
    input wire shared_pin_oe
);
    wire wr_ok = avs_write && !avs_waitrequest;
    reg fn_q, rxi_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    always @(posedge clk_sys) begin
        if (reset) begin
            {fn_q, rxi_q} <= 2'h0;
        end else if (wr_ok && avs_address == 4'h1) begin
            {fn_q, rxi_q} <= {avs_writedata[5], avs_writedata[2]};
        end
    end
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("late answer");
    chk_stop_set: assert property (wr_ok && avs_address == 4'h0 |=>
        channel_run == $past(avs_writedata[5])) else $error("stop bit");
    chk_stop_quiet: assert property (!channel_run [*2] |->
        serial_clk && !bit_strobe) else $error("clock in standby");
    chk_rx_idle: assert property (!channel_run |-> shifter_rx_data)
        else $error("rx in standby");
    chk_rx_inv: assert property (channel_run |->
        shifter_rx_data == (serial_rx_pin ^ rxi_q)) else $error("rx inv");
    chk_port_way: assert property (!fn_q |->
        shared_pin_out == general_port_out && shared_pin_oe == general_port_oe)
        else $error("port route");
    chk_tx_way: assert property (fn_q |-> shared_pin_oe)
        else $error("tx route");
    chk_fixed_ones: assert property (avs_read && !avs_waitrequest &&
        avs_address == 4'h1 |-> (avs_readdata[7:0] & 8'hD3) == 8'hD3)
        else $error("fixed bits");
    cover property (fn_q && shared_pin_oe);
    cover property (bit_strobe);
    cover property (!channel_run);
endmodule

bind scspc_top scspc_chk chk (.*);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ----
// bench
// ----
module tb_top;
    localparam int WATCH_P = 3;
    logic clk_sys = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic watch_tick = 1'b0, sub_mode = 1'b0, shifter_tx_data = 1'b1;
    logic general_port_out = 1'b0, general_port_oe = 1'b0, send = 1'b0;
    logic rx_bit = 1'b1;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0;
    // select code and prescale multiple (clk_sys cycles per tick) per row of the rate table
    logic [1:0] sels [6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
    int ks [6] = '{1, 1, 16, 64, 2 * WATCH_P, WATCH_P};
    wire [31:0] avs_readdata;
    wire avs_waitrequest, shifter_rx_data, channel_run, serial_clk;
    wire bit_strobe, general_port_in, serial_rx_pin, shared_pin_in;
    wire shared_pin_out, shared_pin_oe;
    int n_mismatch = 0, comparisons = 0, wt = 0;
    scspc_top dut (.*);
    scspc_remote far (.send(send), .bit_in(rx_bit), .rx_line(serial_rx_pin),
        .pin_out(shared_pin_out), .pin_oe(shared_pin_oe),
        .pin_level(shared_pin_in));
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        wt <= (wt == WATCH_P - 1) ? 0 : wt + 1;
        watch_tick <= (wt == 0);
        rx_bit <= 1'($urandom);
    end
    function automatic int half_exp(int n, int k);
        return 4 * (n + 1) * k;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(bit w, logic [3:0] a, logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_sys);
        {avs_address, avs_write, avs_read} <= {a, w, !w};
        avs_writedata <= {24'h0, d};
        // hold the request until waitrequest is seen low at a rising edge
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        {avs_write, avs_read} <= 2'h0;
    endtask
    task automatic rd(string nm, logic [3:0] a, logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(nm, q, e);
    endtask
    task automatic half(output int c);
        logic s;
        repeat (3) begin
            s = serial_clk;
            c = 0;
            do begin
                @(negedge clk_sys);
                c++;
            end while (serial_clk === s);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_mismatch++;
        conclude;
    end
    initial begin
        logic [7:0] d, q;
        int c, n;
        void'($urandom(66736));
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        rd("stop reg", 4'h0, 8'hFF);
        rd("pin reg", 4'h1, 8'hD3);
        rd("unmapped", 4'hE, 8'h00);
        repeat (12) begin
            d = $urandom;
            acc(1'b1, 4'h1, d, q);
            acc(1'b1, 4'h4, {2'h0, d[5] & d[0], 5'h0}, q);
            {shifter_tx_data, general_port_out, general_port_oe, send} <=
                4'($urandom);
            @(negedge clk_sys);
            chk("oe", shared_pin_oe, d[5] | general_port_oe);
            n = d[5] ? (shifter_tx_data | !d[0]) ^ d[3] : general_port_out;
            chk("out", shared_pin_out, n[0]);
            chk("rx", shifter_rx_data, serial_rx_pin ^ d[2]);
            chk("port in", general_port_in, shared_pin_in);
            rd("pin rw", 4'h1, d & 8'h2C | 8'hD3);
        end
        acc(1'b1, 4'h0, 8'h00, q);
        acc(1'b1, 4'h2, 8'h05, q);
        rd("stby div", 4'h2, 8'hFF);
        rd("stby ctl", 4'h4, 8'h00);
        @(negedge clk_sys);
        chk("stby", {channel_run, serial_clk, bit_strobe}, 3'h2);
        acc(1'b1, 4'h0, 8'hFF, q);
        @(negedge clk_sys);
        chk("run", channel_run, 1'b1);
        for (int i = 0; i < 6; i++) begin
            n = (i == 0) ? 255 : (i == 1) ? $urandom_range(15) : 0;
            sub_mode <= (i == 5);
            acc(1'b1, 4'h2, n[7:0], q);
            acc(1'b1, 4'h3, {6'h0, sels[i]}, q);
            half(c);
            chk("half", c, half_exp(n, ks[i]));
        end
        conclude;
    end
endmodule
